// File: bench/fts_host_model.sv
// Far-side bus model that resolves the common data pins between host and device.
`timescale 1ns/1ps
`default_nettype none

module fts_host_model
    import fts_pkg::*;
(
    // Clock.
    input wire logic ref_clk,
    // Device side of the pins.
    input wire logic [DATA_W-1:0] data_io_out,
    input wire logic data_io_oe,
    // Host side of the pins.
    input wire logic host_drv,
    input wire logic [DATA_W-1:0] host_d,
    output logic [DATA_W-1:0] data_io_in
);
    // ---------------------------------------------------------------
    // Pin resolution
    // ---------------------------------------------------------------
    logic [DATA_W-1:0] last_reg = '0;

    // Released pins show the inverse of the last level, so a stale value never passes.
    assign data_io_in = data_io_oe ? data_io_out : (host_drv ? host_d : ~last_reg);

    // The last pin level is refreshed every cycle.
    always_ff @(posedge ref_clk)
    begin
        last_reg <= data_io_in;
    end
endmodule : fts_host_model
`default_nettype wire

// File: bench/tb.sv
// Self-checking testbench for the flow-through burst SRAM port.
`timescale 1ns/1ps
`default_nettype none

module tb;
    import fts_pkg::*;

    // ---------------------------------------------------------------
    // Pin drivers and reference state
    // ---------------------------------------------------------------
    typedef struct packed {logic ckd; logic [DATA_W-1:0] d; logic oe;} fts_exp_t;
    localparam fts_exp_t NO_CHK = '0;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [ADDR_W-1:0] addr_in = '0;
    logic [2:0] sel = 3'h6;
    logic ps_n = 1'b1;
    logic cs_n = 1'b1;
    logic step_n = 1'b1;
    logic glob_n = 1'b1;
    logic ben_n = 1'b1;
    logic [LANES-1:0] bs_n = MASK_ALL;
    logic oe_n = 1'b0;
    logic sleep = SLEEP_RST;
    logic strap = MODE_RST;
    logic host_drv = 1'b0;
    logic [DATA_W-1:0] host_d = '0;
    logic [DATA_W-1:0] pin_in;
    logic [DATA_W-1:0] pin_out;
    logic pin_oe;
    logic wr_rdy;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [DATA_W-1:0] mem_m [int];
    fts_exp_t exp_q [$];
    fts_exp_t cur;
    logic cur_v = 1'b0;

    // The clock toggles every half period of 2.5 ns.
    initial
    begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    // ---------------------------------------------------------------
    // Design and far-side model
    // ---------------------------------------------------------------
    fts_sram_port fts_sram_port_i (
        .ref_clk(ref_clk), .rst_b(rst_b), .addr_in(addr_in),
        .chip_select_pipe_n(sel[2]), .chip_select_depth_hi(sel[1]),
        .chip_select_depth_n(sel[0]), .processor_addr_strobe_n(ps_n),
        .controller_addr_strobe_n(cs_n), .burst_advance_n(step_n),
        .global_write_n(glob_n), .byte_write_enable_n(ben_n), .byte_select_n(bs_n),
        .output_enable_n(oe_n), .sleep_request(sleep), .burst_order_strap(strap),
        .data_io_in(pin_in), .data_io_out(pin_out), .data_io_oe(pin_oe),
        .write_ready(wr_rdy)
    );

    fts_host_model fts_host_model_i (
        .ref_clk(ref_clk), .data_io_out(pin_out), .data_io_oe(pin_oe),
        .host_drv(host_drv), .host_d(host_d), .data_io_in(pin_in)
    );

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic cmp(input string what, input logic [DATA_W-1:0] e,
                       input logic [DATA_W-1:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : cmp

    task automatic finish_test();
        if (n_mismatch == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    function automatic logic [DATA_W-1:0] rnd_d();
        return DATA_W'({$urandom, $urandom});
    endfunction : rnd_d

    // One bus cycle: ctl is {processor strobe, controller strobe, advance, global, byte enable}.
    task automatic cyc(input logic [4:0] ctl, input logic [2:0] s, input logic [ADDR_W-1:0] a,
                       input logic [LANES-1:0] b, input logic [DATA_W-1:0] d, input fts_exp_t e);
        @(posedge ref_clk);
        {ps_n, cs_n, step_n, glob_n, ben_n} <= ctl;
        sel <= s;
        addr_in <= a;
        bs_n <= b;
        host_d <= d;
        host_drv <= ~(ctl[1] & ctl[0]);
        exp_q.push_back(e);
    endtask : cyc

    // Quiet cycles, optionally led by a deselecting strobe that closes the session.
    task automatic idle(input int n, input logic ds);
        if (ds)
            cyc(5'h17, 3'h6, '0, MASK_ALL, '0, NO_CHK);
        repeat (n) cyc(5'h1f, 3'h6, '0, MASK_ALL, '0, NO_CHK);
    endtask : idle

    // A four-beat read burst from a closed session, optionally begun with both strobes.
    task automatic burst(input logic [ADDR_W-1:0] a, input logic [BURST_W-1:0] st,
                         input logic both);
        fts_exp_t e;
        logic [ADDR_W-1:0] x;
        for (int k = 0; k < 4; k++)
        begin
            x = {a[ADDR_W-1:2], strap ? (st ^ k[1:0]) : (st + k[1:0])};
            e = '{1'b1, mem_m[int'(x)], k != 0 && !oe_n};
            if (k == 0)
                cyc(both ? 5'h05 : 5'h0f, 3'h2, x, MASK_NONE, rnd_d(), e);
            else
                cyc(5'h1b, 3'h2, ADDR_W'($urandom), MASK_NONE, rnd_d(), e);
        end
        if (both)
            cyc(5'h0f, 3'h6, ADDR_W'($urandom), MASK_NONE, '0,
                '{1'b1, mem_m[int'(x)], !oe_n});
    endtask : burst

    // ---------------------------------------------------------------
    // Output monitor, one cycle behind the drive
    // ---------------------------------------------------------------
    always @(negedge ref_clk)
    begin
        if (cur_v)
        begin
            cmp("data_io_oe", DATA_W'(cur.oe), DATA_W'(pin_oe));
            if (cur.ckd)
                cmp("data_io_out", cur.d, pin_out);
            cmp("write_ready", DATA_W'(1'b1), DATA_W'(wr_rdy));
        end
        cur_v = (exp_q.size() > 0);
        if (cur_v)
            cur = exp_q.pop_front();
    end

    // Watchdog far beyond the expected run length.
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        finish_test();
    end

    // ---------------------------------------------------------------
    // Main sequence, once per burst order
    // ---------------------------------------------------------------
    initial
    begin
        logic [ADDR_W-1:0] base;
        logic [LANES-1:0] m;
        logic [DATA_W-1:0] d;
        logic [DATA_W-1:0] t;
        void'($urandom(32'h66ed));
        for (int md = 1; md >= 0; md--)
        begin
            strap <= md[0];
            oe_n <= !md[0];
            rst_b <= 1'b0;
            repeat (10) @(posedge ref_clk);
            rst_b <= 1'b1;
            idle(4, 1'b0);
            base = ADDR_W'($urandom) & ~ADDR_W'(3);
            for (int i = 0; i < 4; i++)
            begin
                d = rnd_d();
                mem_m[int'(base) + i] = d;
                cyc(5'h15, 3'h2, base + ADDR_W'(i), LANES'($urandom), d, NO_CHK);
            end
            m = LANES'($urandom) & 4'h7;
            d = rnd_d();
            t = mem_m[int'(base) + 2];
            for (int k = 0; k < LANES; k++)
            begin
                if (!m[k])
                    t[k*LANE_W +: LANE_W] = d[k*LANE_W +: LANE_W];
            end
            mem_m[int'(base) + 2] = t;
            cyc(5'h16, 3'h2, base + ADDR_W'(2), m, d, NO_CHK);
            cyc(5'h15, 3'h0, base + ADDR_W'(3), MASK_NONE, rnd_d(), NO_CHK);
            idle(10, 1'b1);
            cyc(5'h17, 3'h2, base + ADDR_W'(1), MASK_NONE, rnd_d(),
                '{1'b1, mem_m[int'(base) + 1], 1'b0});
            idle(2, 1'b1);
            burst(base, BURST_W'($urandom), 1'b1);
            idle(2, 1'b1);
            sleep <= 1'b1;
            idle(12, 1'b0);
            sleep <= 1'b0;
            idle(12, 1'b0);
            burst(base, BURST_W'($urandom), 1'b0);
            idle(2, 1'b1);
        end
        repeat (3) @(posedge ref_clk);
        finish_test();
    end
endmodule : tb
`default_nettype wire

// File: src/fts_pkg.sv
// Constants and types shared by the flow-through burst SRAM port.
//
// Summary of operation
// - Store 131072 words of 36 bits, shared data bus.
// - Register synchronous inputs on rising clock edge.
// - Take address only with strobe and full selection.
// - Strobe loads address register and burst counter.
// - Two-bit burst counter supplies following burst addresses.
// - Advance low during burst steps the counter.
// - Selected when selects one and three low, two high.
// - Processor strobe ignored while select one is high.
// - Both strobes low: only processor strobe acts.
// - Strap low linear, strap high interleaved order.
// - Global write low writes all four bytes.
// - Byte write needs byte write enable low.
// - Byte write stores only selected bytes.
// - Drive data while output enable low, else release.
// - First read clock after deselect keeps pins released.
// - Write data captured from pins at rising edge.
// - Read data for previous edge address, no pipeline.
// - Sleep high enters sleep, contents kept.
// - Interleaved order: start address XOR step count.
// - Linear order: start plus step, modulo four.
// - Sleep entry and exit take two clocks.

package fts_pkg;

    // ---------------------------------------------------------------
    // Array geometry
    // ---------------------------------------------------------------
    localparam int ADDR_W = 17;
    localparam int MEM_WORDS = 131072;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = LANES * LANE_W;
    localparam int BURST_W = 2;

    // ---------------------------------------------------------------
    // Burst order, synchroniser reset values and write buffer
    // ---------------------------------------------------------------
    localparam logic MODE_LINEAR = 1'b0;
    localparam logic MODE_RST = 1'b1;
    localparam logic OE_N_RST = 1'b1;
    localparam logic SLEEP_RST = 1'b0;
    localparam logic [BURST_W-1:0] STEP_ZERO = 2'h0;
    localparam logic [BURST_W-1:0] STEP_ONE = 2'h1;
    localparam logic [LANES-1:0] MASK_ALL = 4'hf;
    localparam logic [LANES-1:0] MASK_NONE = 4'h0;
    localparam int WBUF_DEPTH = 8;
    localparam int WBUF_W = ADDR_W + DATA_W + LANES;

    // ---------------------------------------------------------------
    // Sleep sequencing
    // ---------------------------------------------------------------
    localparam logic [1:0] SLEEP_CYCLES = 2'h2;
    localparam logic [1:0] SLEEP_CNT_ONE = 2'h1;
    localparam logic [1:0] SLEEP_CNT_ZERO = 2'h0;

    typedef enum logic [3:0] {
        FTS_AWAKE = 4'b0001,
        FTS_ENTER = 4'b0010,
        FTS_ASLEEP = 4'b0100,
        FTS_EXIT = 4'b1000
    } fts_sleep_t;

endpackage : fts_pkg

// File: src/fts_sram_port.sv
// Flow-through burst SRAM port: strobes, burst counter, writes, output control.
`timescale 1ns/1ps
`default_nettype none

module fts_sram_port
    import fts_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // Address and selects.
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic chip_select_pipe_n,
    input wire logic chip_select_depth_hi,
    input wire logic chip_select_depth_n,
    // Burst control.
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic burst_advance_n,
    // Write control.
    input wire logic global_write_n,
    input wire logic byte_write_enable_n,
    input wire logic [LANES-1:0] byte_select_n,
    // Asynchronous controls and strap.
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic burst_order_strap,
    // Common data pins, parity bit at the top of each lane.
    input wire logic [DATA_W-1:0] data_io_in,
    output logic [DATA_W-1:0] data_io_out,
    output logic data_io_oe,
    // Write buffer status.
    output logic write_ready
);

    // -------------------------------------------------------------------
    // Synchronisers for the asynchronous pins
    // -------------------------------------------------------------------
    logic oe_meta_reg;
    logic oe_n_reg;
    logic sleep_meta_reg;
    logic sleep_reg;
    logic mode_meta_reg;
    logic mode_reg;

    // Two flops per pin; only the second flop is read by logic.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            oe_meta_reg <= OE_N_RST;
            oe_n_reg <= OE_N_RST;
            sleep_meta_reg <= SLEEP_RST;
            sleep_reg <= SLEEP_RST;
            mode_meta_reg <= MODE_RST;
            mode_reg <= MODE_RST;
        end
        else
        begin
            oe_meta_reg <= output_enable_n;
            oe_n_reg <= oe_meta_reg;
            sleep_meta_reg <= sleep_request;
            sleep_reg <= sleep_meta_reg;
            mode_meta_reg <= burst_order_strap;
            mode_reg <= mode_meta_reg;
        end
    end

    // -------------------------------------------------------------------
    // Sleep sequencer
    // -------------------------------------------------------------------
    fts_sleep_t sleep_state_reg;
    logic [1:0] sleep_cnt_reg;
    logic awake;

    // Entry and exit each spend two clocks before the new state holds.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            sleep_state_reg <= FTS_AWAKE;
            sleep_cnt_reg <= SLEEP_CNT_ZERO;
        end
        else
        begin
            unique case (sleep_state_reg)
                FTS_AWAKE:
                begin
                    sleep_cnt_reg <= SLEEP_CNT_ZERO;
                    if (sleep_reg)
                    begin
                        sleep_state_reg <= FTS_ENTER;
                    end
                end
                FTS_ENTER:
                begin
                    sleep_cnt_reg <= sleep_cnt_reg + SLEEP_CNT_ONE;
                    if (sleep_cnt_reg == SLEEP_CYCLES - SLEEP_CNT_ONE)
                    begin
                        sleep_state_reg <= FTS_ASLEEP;
                    end
                end
                FTS_ASLEEP:
                begin
                    sleep_cnt_reg <= SLEEP_CNT_ZERO;
                    if (!sleep_reg)
                    begin
                        sleep_state_reg <= FTS_EXIT;
                    end
                end
                FTS_EXIT:
                begin
                    sleep_cnt_reg <= sleep_cnt_reg + SLEEP_CNT_ONE;
                    if (sleep_cnt_reg == SLEEP_CYCLES - SLEEP_CNT_ONE)
                    begin
                        sleep_state_reg <= FTS_AWAKE;
                    end
                end
                default:
                begin
                    sleep_state_reg <= FTS_AWAKE;
                    sleep_cnt_reg <= SLEEP_CNT_ZERO;
                end
            endcase
        end
    end

    assign awake = (sleep_state_reg == FTS_AWAKE);

    // -------------------------------------------------------------------
    // Cycle decode on the edge-sampled synchronous inputs
    // -------------------------------------------------------------------
    logic session_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [BURST_W-1:0] step_reg;
    logic selected;
    logic proc_strobe_seen;
    logic ctrl_strobe_seen;
    logic strobe;
    logic start_go;
    logic desel_go;
    logic cont_go;
    logic wr_req;
    logic wr_go;
    logic rd_go;
    logic [LANES-1:0] wr_mask;
    logic [BURST_W-1:0] eff_step;
    logic [BURST_W-1:0] eff_low;
    logic [ADDR_W-1:0] eff_addr;

    // Selection, strobe priority and the kind of cycle at this edge.
    assign selected = !chip_select_pipe_n && chip_select_depth_hi && !chip_select_depth_n;
    assign proc_strobe_seen = !processor_addr_strobe_n && !chip_select_pipe_n;
    assign ctrl_strobe_seen = !controller_addr_strobe_n && !proc_strobe_seen;
    assign strobe = awake && (proc_strobe_seen || ctrl_strobe_seen);
    assign start_go = strobe && selected;
    assign desel_go = strobe && !selected;
    assign cont_go = awake && !strobe && session_reg;

    // Global write covers every lane; otherwise the byte selects decide, gated by byte write enable.
    assign wr_mask = !global_write_n ? MASK_ALL
        : (!byte_write_enable_n ? ~byte_select_n : MASK_NONE);

    // A processor-strobe start ignores the write inputs in its first clock.
    assign wr_req = (wr_mask != MASK_NONE);
    assign wr_go = wr_req && ((start_go && !proc_strobe_seen) || cont_go);
    assign rd_go = (start_go || cont_go) && !wr_go;

    // Burst address: a new start, an advanced step or the held step.
    assign eff_step = start_go ? STEP_ZERO
        : ((cont_go && !burst_advance_n) ? step_reg + STEP_ONE : step_reg);
    assign eff_low = start_go ? addr_in[BURST_W-1:0]
        : ((mode_reg == MODE_LINEAR) ? addr_reg[BURST_W-1:0] + eff_step
        : addr_reg[BURST_W-1:0] ^ eff_step);
    assign eff_addr = start_go ? addr_in : {addr_reg[ADDR_W-1:BURST_W], eff_low};

    // -------------------------------------------------------------------
    // Address register, burst counter and session state
    // -------------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            addr_reg <= '0;
            step_reg <= STEP_ZERO;
        end
        else if (start_go)
        begin
            addr_reg <= addr_in;
            step_reg <= STEP_ZERO;
        end
        else if (cont_go)
        begin
            step_reg <= eff_step;
        end
    end

    // A session lasts from a selected start until a deselect or sleep.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            session_reg <= 1'b0;
        end
        else if (!awake || desel_go)
        begin
            session_reg <= 1'b0;
        end
        else if (start_go)
        begin
            session_reg <= 1'b1;
        end
    end

    // -------------------------------------------------------------------
    // Write buffer and storage array
    // -------------------------------------------------------------------
    logic [WBUF_W-1:0] wbuf_in;
    logic [WBUF_W-1:0] wbuf_out;
    logic wbuf_valid;
    logic drain_go;
    logic [ADDR_W-1:0] drain_addr;
    logic [DATA_W-1:0] drain_data;
    logic [LANES-1:0] drain_mask;
    logic [DATA_W-1:0] rd_data;

    // Write data is taken from the pins at the edge into the buffer.
    assign wbuf_in = {eff_addr, data_io_in, wr_mask};
    assign {drain_addr, drain_data, drain_mask} = wbuf_out;
    // Reads own the array port, so buffered writes wait behind them.
    assign drain_go = wbuf_valid && !rd_go;

    fts_wbuf #(
        .WIDTH(WBUF_W),
        .DEPTH(WBUF_DEPTH)
    ) u_wbuf (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .in_valid(wr_go),
        .in_ready(write_ready),
        .in_data(wbuf_in),
        .out_valid(wbuf_valid),
        .out_ready(drain_go),
        .out_data(wbuf_out)
    );

    // One memory slice per byte lane, written only where its mask bit is set.
    for (genvar g = 0; g < LANES; g++)
    begin : g_lane
        logic [LANE_W-1:0] lane_mem [MEM_WORDS];
        logic [LANE_W-1:0] lane_q_reg;

        always_ff @(posedge ref_clk)
        begin
            if (drain_go && drain_mask[g])
            begin
                lane_mem[drain_addr] <= drain_data[g*LANE_W +: LANE_W];
            end
            if (rd_go)
            begin
                lane_q_reg <= lane_mem[eff_addr];
            end
        end

        assign rd_data[g*LANE_W +: LANE_W] = lane_q_reg;
    end

    // -------------------------------------------------------------------
    // Output drive control
    // -------------------------------------------------------------------
    logic drive_reg;

    // Drive after a read, except the first read clock out of deselect.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            drive_reg <= 1'b0;
        end
        else
        begin
            drive_reg <= rd_go && !(start_go && !session_reg);
        end
    end

    assign data_io_out = rd_data;
    assign data_io_oe = drive_reg && !oe_n_reg && awake;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    chk_addr_capture: assert property (start_go |=> addr_reg == $past(addr_in))
        else $error("Address not captured on accepted strobe.");
    chk_select_gate: assert property (strobe && !selected |=> !session_reg)
        else $error("Session kept after deselecting strobe.");
    chk_proc_strobe_ignored: assert property (chip_select_pipe_n
        && controller_addr_strobe_n |=> $stable(addr_reg))
        else $error("Processor strobe acted with select one high.");
    chk_strobe_priority: assert property (awake && selected && !processor_addr_strobe_n
        && !controller_addr_strobe_n |-> !wr_go)
        else $error("Controller strobe write acted beside processor strobe.");
    chk_burst_hold: assert property (session_reg && !strobe && burst_advance_n
        |=> $stable(step_reg) [*1])
        else $error("Burst counter moved without advance.");
    chk_burst_linear: assert property (cont_go && !burst_advance_n
        && mode_reg == MODE_LINEAR |-> eff_low == addr_reg[BURST_W-1:0] + step_reg + STEP_ONE)
        else $error("Linear burst address wrong.");
    chk_burst_inter: assert property (cont_go && !burst_advance_n
        && mode_reg != MODE_LINEAR |-> eff_low == (addr_reg[BURST_W-1:0] ^ (step_reg + STEP_ONE)))
        else $error("Interleaved burst address wrong.");
    chk_global_write: assert property (wr_go && !global_write_n
        |-> wbuf_in[LANES-1:0] == MASK_ALL)
        else $error("Global write did not cover all lanes.");
    chk_byte_write: assert property (global_write_n && byte_write_enable_n |-> !wr_go)
        else $error("Write without any enable.");
    chk_write_release: assert property (wr_go |=> !data_io_oe)
        else $error("Pins driven after a write cycle.");
    chk_first_read: assert property (rd_go && start_go && !session_reg |=> !data_io_oe)
        else $error("Pins driven on first read out of deselect.");
    chk_sleep_enter: assert property (sleep_state_reg == FTS_AWAKE && sleep_reg
        |=> sleep_state_reg == FTS_ENTER ##2 sleep_state_reg == FTS_ASLEEP)
        else $error("Sleep entry did not take two clocks.");

    cov_burst_read: cover property (start_go && rd_go ##1 cont_go && !burst_advance_n
        ##1 cont_go && !burst_advance_n);
    cov_ctrl_write: cover property (start_go && wr_go);
    cov_wbuf_full: cover property (!write_ready);
    cov_sleep_cycle: cover property (sleep_state_reg == FTS_ASLEEP ##1 sleep_state_reg == FTS_EXIT);

endmodule : fts_sram_port

`default_nettype wire

// File: src/fts_wbuf.sv
// Write buffer FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module fts_wbuf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int PTR_W = $clog2(DEPTH);

    // -------------------------------------------------------------------
    // Storage and pointers
    // -------------------------------------------------------------------
    logic [WIDTH-1:0] store_reg [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [PTR_W:0] count_reg;
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready = (count_reg != (PTR_W+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = store_reg[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Entry storage; no reset needed on the data itself.
    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            store_reg[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers wrap at the depth and the count follows push and pop.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_reg <= (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end

endmodule : fts_wbuf

`default_nettype wire
